//--- insul_alarm_regs.vh
// constants of the insulation alarm settings and register bank
`ifndef INSUL_ALARM_REGS_VH
`define INSUL_ALARM_REGS_VH
// register map, printed register numbers
`define REG_RES        16'h0001
`define REG_CAP        16'h0002
`define REG_ALIM       16'h0005
`define REG_PLIM       16'h0006
`define REG_DELAY      16'h000A
`define REG_CODE       16'h000B
`define REG_STATUS     16'h000C
`define REG_TEST       16'h000D
`define REG_ACK        16'h000F
`define REG_ALIM_MIN   16'h0010
`define REG_ALIM_MAX   16'h0011
`define REG_ALIM_STEP  16'h0012
`define REG_PLIM_MIN   16'h0013
`define REG_PLIM_MAX   16'h0014
`define REG_PLIM_STEP  16'h0015
// function and exception codes
`define FC_READ        8'h03
`define FC_WRITE       8'h06
`define EXC_NONE       8'h00
`define EXC_FUNC       8'h01
`define EXC_ADDR       8'h02
`define EXC_VALUE      8'h03
`define BCAST_ADDR     8'h00
// limit ranges and reset values
`define LIM_MIN        16'h000A
`define LIM_MAX        16'h03E8
`define LIM_KNEE       16'h0064
`define STEP_FINE      16'h000A
`define STEP_COARSE    16'h0032
`define DEF_ALIM       16'h0064
`define DEF_PLIM       16'h01F4
`define DELAY_MAX      16'h003C
`define DEF_DELAY      16'h0000
`define DEF_CODE       16'h007B
`define CODE_MAX       16'h03E7
`define DEF_SLAVE      8'h01
`define SLAVE_MAX      8'hF7
`define DEF_AUTOACK    1'b0
`define CMD_GO         16'h0001
`define HYST_PCT       5
// status bit positions
`define ST_INS         0
`define ST_PRE         1
`define ST_TEST        2
`define ST_GND         4
`define ST_TBUSY       8
`define ST_CAL         9
// local setting selectors
`define SEL_ALIM       3'h0
`define SEL_PLIM       3'h1
`define SEL_AUTOACK    3'h2
`define SEL_DELAY      3'h3
`define SEL_SLAVE      3'h4
`define SEL_FACTORY    3'h5
`define SEL_CODE       3'h6
// timing
`define CLK_FREQ_HZ    100000000
`define BLINK_HALF_MS  250
`endif

//--- alarm_latch.v
// one alarm channel: active flag with suppression and unacknowledged memory
`timescale 1ns/1ps
module alarm_latch (
  input  wire clk_i,
  input  wire srst_i,
  input  wire hold_i,
  input  wire set_i,
  input  wire clr_i,
  input  wire ack_i,
  input  wire auto_ack_i,
  output reg  active_o,
  output reg  old_o
);
  wire fall;

  // cause going inactive; with auto acknowledge it never becomes old
  assign fall = active_o & ~set_i & clr_i & ~hold_i;

  // set wins over clear so a fresh fault is lost only while hold is asserted
  always @(posedge clk_i) begin
    if (srst_i) begin
      active_o <= 1'b0;
      old_o    <= 1'b0;
    end else begin
      if (hold_i) begin
        active_o <= 1'b0;
      end else if (set_i) begin
        active_o <= 1'b1;
      end else if (clr_i) begin
        active_o <= 1'b0;
      end
      if (fall & ~auto_ack_i) begin
        old_o <= 1'b1;
      end else if (ack_i | auto_ack_i | (set_i & ~hold_i)) begin
        old_o <= 1'b0;
      end
    end
  end
endmodule // alarm_latch

//--- insulation_alarm_settings_regs.v
// settings, alarm indication and remote register bank of the insulation monitor
`timescale 1ns/1ps
`include "insul_alarm_regs.vh"
module insulation_alarm_settings_regs #(
  parameter HALF_CYCLES = `CLK_FREQ_HZ / 1000 * `BLINK_HALF_MS
) (
  input  wire        CLK_SYS_I,
  input  wire        SRST_I,
  // measurement results, same clock
  input  wire        MEAS_VALID_I,
  input  wire [15:0] MEAS_RES_I,
  input  wire [15:0] MEAS_CAP_I,
  input  wire        CAL_BUSY_I,
  input  wire        SELFTEST_BUSY_I,
  input  wire        SELFTEST_FAIL_I,
  output reg         SELFTEST_START_O,
  // earth sense wires, high while connected, asynchronous pins
  input  wire        EARTH_SENSE_WIRE_A_I,
  input  wire        EARTH_SENSE_WIRE_B_I,
  // local panel, same clock
  input  wire        LOCAL_DIGIT_STB_I,
  input  wire [3:0]  LOCAL_DIGIT_I,
  input  wire        LOCAL_ENTER_I,
  input  wire        LOCAL_LOCK_I,
  input  wire        LOCAL_WR_I,
  input  wire [2:0]  LOCAL_SEL_I,
  input  wire [15:0] LOCAL_WDATA_I,
  input  wire        LOCAL_ACK_I,
  output reg         SETUP_UNLOCKED_O,
  output reg         LOCAL_WR_ERR_O,
  // modbus request from the frame layer
  input  wire        MB_REQ_I,
  input  wire [7:0]  MB_SLAVE_I,
  input  wire [7:0]  MB_FUNC_I,
  input  wire [15:0] MB_ADDR_I,
  input  wire [15:0] MB_WDATA_I,
  output reg         MB_ACK_O,
  output reg  [7:0]  MB_EXC_O,
  output reg  [15:0] MB_RDATA_O,
  output wire [7:0]  SLAVE_ADDR_O,
  output wire        AUTO_ACK_OPTION_O,
  // indicators, relays high = energised = healthy
  output reg         LED_ALARM_O,
  output reg         LED_STATUS_O,
  output reg         LED_WARN_O,
  output reg         MAIN_ALARM_RELAY_O,
  output reg         WARNING_RELAY_O
);
  reg  [15:0] res_q, cap_q;
  reg  [15:0] alarm_limit_setting_q, prealarm_limit_setting_q;
  reg  [15:0] power_on_alarm_holdoff_q, code_q;
  reg  [7:0]  slave_q;
  reg         auto_ack_option_q;
  reg         test_req_q, ack_req_q;
  reg  [11:0] entry_q;
  reg  [1:0]  digits_q;
  reg  [1:0]  sync_a_q, sync_b_q;
  reg  [31:0] half_cnt_q;
  reg         half_tick_q, blink_q, sec_tick_q;
  reg  [15:0] sec_cnt_q;
  reg         hold_q;
  reg         wr_ok, rd_ok;
  reg  [7:0]  exc;
  reg  [15:0] rdata;
  wire        addressed, gnd_fault, act_set, ack_all;
  wire [15:0] status;
  wire [15:0] astep;
  wire [31:0] a_hyst, p_hyst;
  wire        act_ins, act_pre, act_tst, act_gnd;
  wire        old_ins, old_pre, old_tst, old_gnd;

  // limit legality: range plus step grid that depends on the value
  function lim_ok;
    input [15:0] v;
    begin
      lim_ok = (v >= `LIM_MIN) && (v <= `LIM_MAX) &&
               ((v < `LIM_KNEE) ? (v % `STEP_FINE == 16'h0000) : (v % `STEP_COARSE == 16'h0000));
    end
  endfunction

  // earth wires are pins from outside, two flops before any use
  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      sync_a_q <= 2'b11;
      sync_b_q <= 2'b11;
    end else begin
      sync_a_q <= {sync_a_q[0], EARTH_SENSE_WIRE_A_I};
      sync_b_q <= {sync_b_q[0], EARTH_SENSE_WIRE_B_I};
    end
  end
  assign gnd_fault = ~sync_a_q[1] | ~sync_b_q[1];

  // quarter-second divider (250 ms) gives blink phase and the half-second tick on every second pulse
  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      half_cnt_q  <= 32'h00000000;
      half_tick_q <= 1'b0;
      blink_q     <= 1'b0;
      sec_tick_q  <= 1'b0;
    end else begin
      half_tick_q <= 1'b0;
      sec_tick_q  <= 1'b0;
      if (half_cnt_q == HALF_CYCLES - 1) begin
        half_cnt_q  <= 32'h00000000;
        half_tick_q <= 1'b1;
        blink_q     <= ~blink_q;
        sec_tick_q  <= blink_q;
      end else begin
        half_cnt_q <= half_cnt_q + 32'h00000001;
      end
    end
  end

  // start-up holdoff counts half-second ticks once after reset
  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      sec_cnt_q <= 16'h0000;
      hold_q    <= 1'b1;
    end else if (hold_q) begin
      if (sec_cnt_q >= power_on_alarm_holdoff_q) begin
        hold_q <= 1'b0;
      end else if (sec_tick_q) begin
        sec_cnt_q <= sec_cnt_q + 16'h0001;
      end
    end
  end

  // resistance and capacitance latched together
  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      res_q <= 16'hFFFF;
      cap_q <= 16'h0000;
    end else if (MEAS_VALID_I) begin
      res_q <= MEAS_RES_I;
      cap_q <= MEAS_CAP_I;
    end
  end

  // access code entry: last three digits compared on enter
  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      entry_q          <= 12'h000;
      digits_q         <= 2'h0;
      SETUP_UNLOCKED_O <= 1'b0;
    end else begin
      if (LOCAL_DIGIT_STB_I) begin
        entry_q <= {entry_q[7:0], LOCAL_DIGIT_I};
        if (digits_q != 2'h3) begin
          digits_q <= digits_q + 2'h1;
        end
      end
      if (LOCAL_LOCK_I) begin
        SETUP_UNLOCKED_O <= 1'b0;
      end else if (LOCAL_ENTER_I) begin
        SETUP_UNLOCKED_O <= (digits_q == 2'h3) &&
          (({12'h000, entry_q[11:8]} * 16'h0064 + {12'h000, entry_q[7:4]} * 16'h000A +
            {12'h000, entry_q[3:0]}) == code_q);
        digits_q <= 2'h0;
      end
    end
  end

  // request addressed to us; broadcast writes act without an answer
  assign addressed = MB_REQ_I && (MB_SLAVE_I == slave_q ||
                     (MB_SLAVE_I == `BCAST_ADDR && MB_FUNC_I == `FC_WRITE));

  // write legality and exception code
  always @* begin
    exc   = `EXC_NONE;
    wr_ok = 1'b0;
    rd_ok = 1'b0;
    if (MB_FUNC_I != `FC_READ && MB_FUNC_I != `FC_WRITE) begin
      exc = `EXC_FUNC;
    end else if (MB_FUNC_I == `FC_READ) begin
      if (MB_ADDR_I == `REG_RES || MB_ADDR_I == `REG_CAP || MB_ADDR_I == `REG_ALIM ||
          MB_ADDR_I == `REG_PLIM || MB_ADDR_I == `REG_DELAY || MB_ADDR_I == `REG_CODE ||
          MB_ADDR_I == `REG_STATUS || MB_ADDR_I == `REG_TEST || MB_ADDR_I == `REG_ACK ||
          (MB_ADDR_I >= `REG_ALIM_MIN && MB_ADDR_I <= `REG_PLIM_STEP)) begin
        rd_ok = 1'b1;
      end else begin
        exc = `EXC_ADDR;
      end
    end else if (MB_ADDR_I == `REG_ALIM) begin
      wr_ok = lim_ok(MB_WDATA_I) && MB_WDATA_I <= prealarm_limit_setting_q;
      exc   = wr_ok ? `EXC_NONE : `EXC_VALUE;
    end else if (MB_ADDR_I == `REG_PLIM) begin
      wr_ok = lim_ok(MB_WDATA_I) && MB_WDATA_I >= alarm_limit_setting_q;
      exc   = wr_ok ? `EXC_NONE : `EXC_VALUE;
    end else if (MB_ADDR_I == `REG_DELAY) begin
      wr_ok = MB_WDATA_I <= `DELAY_MAX;
      exc   = wr_ok ? `EXC_NONE : `EXC_VALUE;
    end else if (MB_ADDR_I == `REG_TEST || MB_ADDR_I == `REG_ACK) begin
      wr_ok = 1'b1;
    end else begin
      exc = `EXC_ADDR;
    end
  end

  assign astep = (alarm_limit_setting_q >= `LIM_KNEE) ? `STEP_COARSE : `STEP_FINE;

  // read data mux
  always @* begin
    rdata = 16'h0000;
    if (MB_ADDR_I == `REG_RES) begin
      rdata = res_q;
    end else if (MB_ADDR_I == `REG_CAP) begin
      rdata = cap_q;
    end else if (MB_ADDR_I == `REG_ALIM) begin
      rdata = alarm_limit_setting_q;
    end else if (MB_ADDR_I == `REG_PLIM) begin
      rdata = prealarm_limit_setting_q;
    end else if (MB_ADDR_I == `REG_DELAY) begin
      rdata = power_on_alarm_holdoff_q;
    end else if (MB_ADDR_I == `REG_CODE) begin
      rdata = code_q;
    end else if (MB_ADDR_I == `REG_STATUS) begin
      rdata = status;
    end else if (MB_ADDR_I == `REG_TEST) begin
      rdata = {15'h0000, test_req_q};
    end else if (MB_ADDR_I == `REG_ACK) begin
      rdata = {15'h0000, ack_req_q};
    end else if (MB_ADDR_I == `REG_ALIM_MIN || MB_ADDR_I == `REG_PLIM_MIN) begin
      rdata = `LIM_MIN;
    end else if (MB_ADDR_I == `REG_ALIM_MAX || MB_ADDR_I == `REG_PLIM_MAX) begin
      rdata = `LIM_MAX;
    end else if (MB_ADDR_I == `REG_ALIM_STEP || MB_ADDR_I == `REG_PLIM_STEP) begin
      rdata = astep;
    end
  end

  // answer one cycle after the request; foreign addresses get none
  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      MB_ACK_O   <= 1'b0;
      MB_EXC_O   <= `EXC_NONE;
      MB_RDATA_O <= 16'h0000;
    end else begin
      MB_ACK_O <= addressed && MB_SLAVE_I != `BCAST_ADDR;
      if (addressed) begin
        MB_EXC_O   <= exc;
        MB_RDATA_O <= (rd_ok ? rdata : (wr_ok ? MB_WDATA_I : 16'h0000));
      end
    end
  end

  // stored settings: remote writes, local writes when unlocked, factory restore
  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      alarm_limit_setting_q    <= `DEF_ALIM;
      prealarm_limit_setting_q <= `DEF_PLIM;
      power_on_alarm_holdoff_q <= `DEF_DELAY;
      code_q                   <= `DEF_CODE;
      slave_q                  <= `DEF_SLAVE;
      auto_ack_option_q        <= `DEF_AUTOACK;
      LOCAL_WR_ERR_O           <= 1'b0;
    end else begin
      LOCAL_WR_ERR_O <= 1'b0;
      if (addressed && wr_ok && MB_ADDR_I == `REG_ALIM) begin
        alarm_limit_setting_q <= MB_WDATA_I;
      end
      if (addressed && wr_ok && MB_ADDR_I == `REG_PLIM) begin
        prealarm_limit_setting_q <= MB_WDATA_I;
      end
      if (addressed && wr_ok && MB_ADDR_I == `REG_DELAY) begin
        power_on_alarm_holdoff_q <= MB_WDATA_I;
      end
      // panel edits are refused with an error in any cycle that carries an addressed remote request, whatever the setting
      if (LOCAL_WR_I && SETUP_UNLOCKED_O && !addressed) begin
        if (LOCAL_SEL_I == `SEL_ALIM && lim_ok(LOCAL_WDATA_I) &&
            LOCAL_WDATA_I <= prealarm_limit_setting_q) begin
          alarm_limit_setting_q <= LOCAL_WDATA_I;
        end else if (LOCAL_SEL_I == `SEL_PLIM && lim_ok(LOCAL_WDATA_I) &&
                     LOCAL_WDATA_I >= alarm_limit_setting_q) begin
          prealarm_limit_setting_q <= LOCAL_WDATA_I;
        end else if (LOCAL_SEL_I == `SEL_AUTOACK) begin
          auto_ack_option_q <= LOCAL_WDATA_I[0];
        end else if (LOCAL_SEL_I == `SEL_DELAY && LOCAL_WDATA_I <= `DELAY_MAX) begin
          power_on_alarm_holdoff_q <= LOCAL_WDATA_I;
        end else if (LOCAL_SEL_I == `SEL_SLAVE && LOCAL_WDATA_I[15:8] == 8'h00 &&
                     LOCAL_WDATA_I[7:0] != `BCAST_ADDR && LOCAL_WDATA_I[7:0] <= `SLAVE_MAX) begin
          slave_q <= LOCAL_WDATA_I[7:0];
        end else if (LOCAL_SEL_I == `SEL_CODE && LOCAL_WDATA_I <= `CODE_MAX) begin
          code_q <= LOCAL_WDATA_I;
        end else if (LOCAL_SEL_I == `SEL_FACTORY) begin
          alarm_limit_setting_q    <= `DEF_ALIM;
          prealarm_limit_setting_q <= `DEF_PLIM;
          power_on_alarm_holdoff_q <= `DEF_DELAY;
          code_q                   <= `DEF_CODE;
          slave_q                  <= `DEF_SLAVE;
          auto_ack_option_q        <= `DEF_AUTOACK;
        end else begin
          LOCAL_WR_ERR_O <= 1'b1;
        end
      end else if (LOCAL_WR_I) begin
        LOCAL_WR_ERR_O <= 1'b1;
      end
    end
  end
  assign SLAVE_ADDR_O      = slave_q;
  assign AUTO_ACK_OPTION_O = auto_ack_option_q;

  // command registers hold the request one cycle, then self-clear
  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      test_req_q       <= 1'b0;
      ack_req_q        <= 1'b0;
      SELFTEST_START_O <= 1'b0;
    end else begin
      SELFTEST_START_O <= test_req_q;
      test_req_q <= addressed && wr_ok && MB_ADDR_I == `REG_TEST && MB_WDATA_I == `CMD_GO;
      ack_req_q  <= addressed && wr_ok && MB_ADDR_I == `REG_ACK && MB_WDATA_I == `CMD_GO;
    end
  end
  assign ack_all = ack_req_q | LOCAL_ACK_I;

  // hysteresis: clear only 5 percent past the limit on the safe side
  assign a_hyst = {16'h0000, alarm_limit_setting_q} + {16'h0000, alarm_limit_setting_q} * `HYST_PCT / 100;
  assign p_hyst = {16'h0000, prealarm_limit_setting_q} + {16'h0000, prealarm_limit_setting_q} * `HYST_PCT / 100;
  // calibration freezes both measured channels; test failure or open earth wire forces the insulation alarm and blocks its clear
  assign act_set = act_tst | act_gnd;

  alarm_latch u_ins (
    .clk_i      (CLK_SYS_I),
    .srst_i     (SRST_I),
    .hold_i     (hold_q),
    .set_i      ((res_q < alarm_limit_setting_q && !CAL_BUSY_I) || act_set),
    .clr_i      ({16'h0000, res_q} >= a_hyst && !CAL_BUSY_I && !act_set),
    .ack_i      (ack_all),
    .auto_ack_i (auto_ack_option_q),
    .active_o   (act_ins),
    .old_o      (old_ins)
  );
  alarm_latch u_pre (
    .clk_i      (CLK_SYS_I),
    .srst_i     (SRST_I),
    .hold_i     (hold_q),
    .set_i      (res_q < prealarm_limit_setting_q && !CAL_BUSY_I),
    .clr_i      ({16'h0000, res_q} >= p_hyst && !CAL_BUSY_I),
    .ack_i      (ack_all),
    .auto_ack_i (auto_ack_option_q),
    .active_o   (act_pre),
    .old_o      (old_pre)
  );
  alarm_latch u_tst (
    .clk_i      (CLK_SYS_I),
    .srst_i     (SRST_I),
    .hold_i     (hold_q),
    .set_i      (SELFTEST_FAIL_I),
    .clr_i      (~SELFTEST_FAIL_I),
    .ack_i      (ack_all),
    .auto_ack_i (auto_ack_option_q),
    .active_o   (act_tst),
    .old_o      (old_tst)
  );
  alarm_latch u_gnd (
    .clk_i      (CLK_SYS_I),
    .srst_i     (SRST_I),
    .hold_i     (hold_q),
    .set_i      (gnd_fault),
    .clr_i      (~gnd_fault),
    .ack_i      (ack_all),
    .auto_ack_i (auto_ack_option_q),
    .active_o   (act_gnd),
    .old_o      (old_gnd)
  );

  // status register mirrors live causes
  assign status = {6'h00, CAL_BUSY_I, SELFTEST_BUSY_I, 3'h0, act_gnd, 1'b0, act_tst, act_pre, act_ins};

  // indicators blink while active, steady when old; relays drop out on alarm
  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      LED_ALARM_O        <= 1'b0;
      LED_STATUS_O       <= 1'b0;
      LED_WARN_O         <= 1'b0;
      MAIN_ALARM_RELAY_O <= 1'b0;
      WARNING_RELAY_O    <= 1'b0;
    end else begin
      LED_ALARM_O  <= (act_ins | act_tst | act_gnd) ? blink_q : (old_ins | old_tst | old_gnd);
      LED_STATUS_O <= (act_tst | act_gnd) ? blink_q : (old_tst | old_gnd);
      LED_WARN_O   <= act_pre ? blink_q : old_pre;
      // energised only while healthy, so a dead supply reads as alarm
      MAIN_ALARM_RELAY_O <= ~(act_ins | act_tst | act_gnd);
      WARNING_RELAY_O    <= ~act_pre;
    end
  end
endmodule // insulation_alarm_settings_regs

//--- insul_checker_assertions.sv
// port assertions for the insulation alarm register bank
`timescale 1ns/1ps
module insul_checker (
  input wire        CLK_SYS_I,
  input wire        SRST_I,
  input wire        MB_REQ_I,
  input wire [7:0]  MB_SLAVE_I,
  input wire [7:0]  MB_FUNC_I,
  input wire [15:0] MB_ADDR_I,
  input wire [15:0] MB_WDATA_I,
  input wire        MB_ACK_O,
  input wire [7:0]  MB_EXC_O,
  input wire [15:0] MB_RDATA_O,
  input wire [7:0]  SLAVE_ADDR_O,
  input wire        SELFTEST_START_O,
  input wire        SELFTEST_FAIL_I,
  input wire        EARTH_SENSE_WIRE_A_I,
  input wire        MAIN_ALARM_RELAY_O,
  input wire        WARNING_RELAY_O,
  input wire        LOCAL_WR_I,
  input wire        SETUP_UNLOCKED_O,
  input wire        LOCAL_WR_ERR_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  // request addressed to this slave; broadcast never answers
  wire hit = MB_REQ_I && (MB_SLAVE_I == SLAVE_ADDR_O);
  wire rd  = hit && (MB_FUNC_I == 8'h03);
  wire go  = hit && (MB_FUNC_I == 8'h06) && (MB_ADDR_I == 16'h000D) && (MB_WDATA_I == 16'h0001);

  property p_ack_taken; hit |=> MB_ACK_O; endproperty
  a_ack_taken: assert property (p_ack_taken) else $error("own request not answered");
  property p_ack_foreign; !hit |=> !MB_ACK_O; endproperty
  a_ack_foreign: assert property (p_ack_foreign) else $error("answer without own request");
  property p_bad_func; hit && MB_FUNC_I != 8'h03 && MB_FUNC_I != 8'h06 |=> MB_EXC_O == 8'h01; endproperty
  a_bad_func: assert property (p_bad_func) else $error("bad function not refused");
  property p_lim_min; rd && MB_ADDR_I == 16'h0010 |=> MB_EXC_O == 8'h00 && MB_RDATA_O == 16'h000A; endproperty
  a_lim_min: assert property (p_lim_min) else $error("limit minimum wrong");
  property p_pre_max; rd && MB_ADDR_I == 16'h0014 |=> MB_RDATA_O == 16'h03E8; endproperty
  a_pre_max: assert property (p_pre_max) else $error("prealarm maximum wrong");
  property p_start; go |-> ##2 SELFTEST_START_O; endproperty
  a_start: assert property (p_start) else $error("self-test not started");
  property p_start_cause; SELFTEST_START_O |-> $past(MB_REQ_I, 2); endproperty
  a_start_cause: assert property (p_start_cause) else $error("self-test start without request");
  property p_hold; !MB_REQ_I |=> $stable(MB_RDATA_O) && $stable(MB_EXC_O); endproperty
  a_hold: assert property (p_hold) else $error("answer changed without request");
  property p_earth; !EARTH_SENSE_WIRE_A_I [*6] |-> !MAIN_ALARM_RELAY_O; endproperty
  a_earth: assert property (p_earth) else $error("open earth wire kept relay healthy");
  property p_fail; SELFTEST_FAIL_I [*5] |-> !MAIN_ALARM_RELAY_O; endproperty
  a_fail: assert property (p_fail) else $error("failed test kept relay healthy");
  property p_wr_err; LOCAL_WR_I && !SETUP_UNLOCKED_O |=> LOCAL_WR_ERR_O; endproperty
  a_wr_err: assert property (p_wr_err) else $error("locked write not rejected");
  // relays must sit in alarm while reset holds, so no disable here
  property p_reset; disable iff (1'b0) SRST_I |=> !MAIN_ALARM_RELAY_O && !WARNING_RELAY_O; endproperty
  a_reset: assert property (p_reset) else $error("relay energised in reset");

  c_alarm: cover property ($fell(MAIN_ALARM_RELAY_O));
  c_start: cover property (SELFTEST_START_O);
  c_refuse: cover property (MB_ACK_O && MB_EXC_O == 8'h03);
endmodule // insul_checker

//--- modbus_master_model.sv
// function-level bus master on the far side of the register bank
`timescale 1ns/1ps
module modbus_master_model (
  input  wire        clk_i,
  input  wire        ack_i,
  input  wire [7:0]  exc_i,
  input  wire [15:0] rdata_i,
  output reg         req_o,
  output reg  [7:0]  slave_o,
  output reg  [7:0]  func_o,
  output reg  [15:0] addr_o,
  output reg  [15:0] wdata_o
);
  initial {req_o, slave_o, func_o, addr_o, wdata_o} = 49'h0;
  // one request over one taken edge; fields inverted after, so stale values never match
  task xfer(input [7:0] s, input [7:0] f, input [15:0] a, input [15:0] d,
            output g, output [7:0] e, output [15:0] r);
    begin
      @(negedge clk_i);
      {req_o, slave_o, func_o, addr_o, wdata_o} = {1'b1, s, f, a, d};
      @(negedge clk_i);
      g = ack_i;
      e = exc_i;
      r = rdata_i;
      {req_o, slave_o, func_o, addr_o, wdata_o} = {1'b0, ~s, ~f, ~a, ~d};
    end
  endtask
endmodule // modbus_master_model

//--- testbench.sv
// self-checking bench of the insulation alarm register bank
`timescale 1ns/1ps
module testbench;
  reg         clk, srst, mv, cal, tbusy, tfail, ea, eb, dstb, ent, lck, lwr, lack, g, l1;
  reg  [15:0] res, lwd, r;
  reg  [7:0]  sl, e;
  reg  [3:0]  dv;
  reg  [2:0]  lsel;
  wire        req, ack, start, unl, werr, aao, led_a, led_s, led_w, rl_m, rl_w;
  wire [7:0]  slv, fn, exc, sadr;
  wire [15:0] adr, wd, rdat;
  integer     num_errors = 0, n_tests = 0, starts = 0, i;
  // bus ops: function, address, data, expected exception, expected read data
  reg  [63:0] ops [0:28] = '{
    64'h03_0005_0000_00_0064, 64'h03_0006_0000_00_01F4, 64'h03_000A_0000_00_0000,
    64'h03_000B_0000_00_007B, 64'h03_0010_0000_00_000A, 64'h03_0011_0000_00_03E8,
    64'h03_0012_0000_00_0032, 64'h03_0013_0000_00_000A, 64'h03_0014_0000_00_03E8,
    64'h03_0015_0000_00_0032, 64'h03_0001_0000_00_0258, 64'h03_0002_0000_00_0005,
    64'h06_0005_005F_03_0000, 64'h06_0005_041A_03_0000, 64'h06_0005_0258_03_0000,
    64'h06_0005_005A_00_005A, 64'h03_0012_0000_00_000A, 64'h03_0015_0000_00_000A,
    64'h06_0006_0050_03_0000, 64'h06_0006_020D_03_0000, 64'h06_0006_0226_00_0226,
    64'h06_000A_003D_03_0000, 64'h06_000A_003C_00_003C, 64'h03_0005_0000_00_005A,
    64'h03_000A_0000_00_003C, 64'h04_0001_0000_01_0000, 64'h03_0003_0000_02_0000,
    64'h06_0001_0005_02_0000, 64'h06_000A_0000_00_0000};

  insulation_alarm_settings_regs #(.HALF_CYCLES(10)) uut (
    .CLK_SYS_I(clk), .SRST_I(srst), .MEAS_VALID_I(mv), .MEAS_RES_I(res), .MEAS_CAP_I(16'h0005),
    .CAL_BUSY_I(cal), .SELFTEST_BUSY_I(tbusy), .SELFTEST_FAIL_I(tfail), .SELFTEST_START_O(start),
    .EARTH_SENSE_WIRE_A_I(ea), .EARTH_SENSE_WIRE_B_I(eb), .LOCAL_DIGIT_STB_I(dstb),
    .LOCAL_DIGIT_I(dv), .LOCAL_ENTER_I(ent), .LOCAL_LOCK_I(lck), .LOCAL_WR_I(lwr),
    .LOCAL_SEL_I(lsel), .LOCAL_WDATA_I(lwd), .LOCAL_ACK_I(lack), .SETUP_UNLOCKED_O(unl),
    .LOCAL_WR_ERR_O(werr), .MB_REQ_I(req), .MB_SLAVE_I(slv), .MB_FUNC_I(fn), .MB_ADDR_I(adr),
    .MB_WDATA_I(wd), .MB_ACK_O(ack), .MB_EXC_O(exc), .MB_RDATA_O(rdat), .SLAVE_ADDR_O(sadr),
    .AUTO_ACK_OPTION_O(aao), .LED_ALARM_O(led_a), .LED_STATUS_O(led_s), .LED_WARN_O(led_w),
    .MAIN_ALARM_RELAY_O(rl_m), .WARNING_RELAY_O(rl_w));
  modbus_master_model mm (.clk_i(clk), .ack_i(ack), .exc_i(exc), .rdata_i(rdat), .req_o(req),
    .slave_o(slv), .func_o(fn), .addr_o(adr), .wdata_o(wd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // count self-test launches
  always @(posedge clk) if (start === 1'b1) starts = starts + 1;
  // a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge clk);
    num_errors = num_errors + 1;
    finish_test;
  end

  task chk(input string n, input [15:0] s, input [15:0] x);
    begin
      n_tests = n_tests + 1;
      if (s !== x) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      end
    end
  endtask
  task finish_test;
    begin
      if (num_errors == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task mb(input [63:0] op);
    begin
      mm.xfer(sl, op[63:56], op[55:40], op[39:24], g, e, r);
      chk("ack", g, 1'b1);
      chk("exc", e, op[23:16]);
      if (op[23:16] == 8'h00) chk("rdata", r, op[15:0]);
    end
  endtask
  // k: 0 relock, 1 local acknowledge, 2 measurement
  task strobe(input integer k);
    begin
      @(negedge clk);
      {lck, lack, mv} = 3'b100 >> k;
      @(negedge clk);
      {lck, lack, mv} = 3'b000;
      repeat (6) @(negedge clk);
    end
  endtask
  task meas(input [15:0] v);
    begin
      res = v;
      strobe(2);
    end
  endtask
  task loc(input [2:0] s, input [15:0] d);
    begin
      @(negedge clk);
      {lwr, lsel, lwd} = {1'b1, s, d};
      @(negedge clk);
      lwr = 1'b0;
      @(negedge clk);
    end
  endtask
  // digits 1, 2, 3 then enter
  task unlock;
    integer j;
    begin
      for (j = 1; j <= 4; j = j + 1) begin
        @(negedge clk);
        dv = j[3:0];
        {dstb, ent} = (j < 4) ? 2'b10 : 2'b01;
        @(negedge clk);
        {dstb, ent} = 2'b00;
      end
    end
  endtask

  initial begin
    {mv, cal, tbusy, tfail, dstb, ent, lck, lwr, lack} = 9'h000;
    {srst, ea, eb} = 3'b111;
    {res, lwd, dv, lsel, sl} = {16'h0258, 16'h0000, 4'h0, 3'h0, 8'h01};
    repeat (10) @(negedge clk);
    chk("relay_m", rl_m, 1'b0);
    chk("relay_w", rl_w, 1'b0);
    srst = 1'b0;
    meas(16'd600);
    chk("relay_m", rl_m, 1'b1);
    {cal, tbusy} = 2'b11;
    mb(64'h03_000C_0000_00_0300);
    {cal, tbusy} = 2'b00;
    for (i = 0; i < 29; i = i + 1)
      mb(ops[i]);
    meas(16'd80);
    chk("relay_m", rl_m, 1'b0);
    chk("relay_w", rl_w, 1'b0);
    mb(64'h03_000C_0000_00_0003);
    @(negedge clk);
    l1 = led_a;
    repeat (10) @(negedge clk);
    chk("led_blink", led_a, !l1);
    meas(16'd93);
    chk("relay_m", rl_m, 1'b0);
    meas(16'd600);
    chk("relay_m", rl_m, 1'b1);
    chk("led_old", led_a, 1'b1);
    chk("led_warn", led_w, 1'b1);
    mb(64'h03_000C_0000_00_0000);
    mb(64'h06_000F_0002_00_0002);
    chk("led_old", led_a, 1'b1);
    mb(64'h06_000F_0001_00_0001);
    repeat (3) @(negedge clk);
    chk("led_ack", led_a, 1'b0);
    chk("led_warn", led_w, 1'b0);
    mb(64'h06_000D_0002_00_0002);
    mb(64'h06_000D_0001_00_0001);
    repeat (2) @(negedge clk);
    chk("starts", starts[15:0], 16'h0001);
    tfail = 1'b1;
    repeat (6) @(negedge clk);
    chk("relay_m", rl_m, 1'b0);
    l1 = led_s;
    repeat (10) @(negedge clk);
    chk("led_stat", led_s, !l1);
    mb(64'h03_000C_0000_00_0005);
    tfail = 1'b0;
    meas(16'd600);
    strobe(1);
    // each earth wire on its own
    for (i = 0; i < 2; i = i + 1) begin
      {ea, eb} = i ? 2'b10 : 2'b01;
      repeat (8) @(negedge clk);
      chk("relay_m", rl_m, 1'b0);
      l1 = led_s;
      repeat (10) @(negedge clk);
      chk("led_stat", led_s, !l1);
      mb(64'h03_000C_0000_00_0011);
      {ea, eb} = 2'b11;
      meas(16'd600);
      strobe(1);
    end
    chk("relay_m", rl_m, 1'b1);
    unlock;
    loc(3'h2, 16'h0001);
    chk("autoack", aao, 1'b1);
    meas(16'd80);
    meas(16'd600);
    chk("led_auto", led_a, 1'b0);
    loc(3'h4, 16'h0005);
    chk("slave", sadr, 8'h05);
    mm.xfer(8'h01, 8'h03, 16'h000B, 16'h0000, g, e, r);
    chk("ack_other", g, 1'b0);
    sl = 8'h05;
    mb(64'h03_000B_0000_00_007B);
    strobe(0);
    loc(3'h0, 16'h0032);
    mb(64'h03_0005_0000_00_005A);
    unlock;
    loc(3'h5, 16'h0000);
    sl = 8'h01;
    chk("slave", sadr, 8'h01);
    chk("autoack", aao, 1'b0);
    mb(64'h03_0005_0000_00_0064);
    mb(64'h03_0006_0000_00_01F4);
    finish_test;
  end
endmodule // testbench

bind insulation_alarm_settings_regs insul_checker chk_u (.CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I),
  .MB_REQ_I(MB_REQ_I), .MB_SLAVE_I(MB_SLAVE_I), .MB_FUNC_I(MB_FUNC_I), .MB_ADDR_I(MB_ADDR_I),
  .MB_WDATA_I(MB_WDATA_I), .MB_ACK_O(MB_ACK_O), .MB_EXC_O(MB_EXC_O), .MB_RDATA_O(MB_RDATA_O),
  .SLAVE_ADDR_O(SLAVE_ADDR_O), .SELFTEST_START_O(SELFTEST_START_O), .SELFTEST_FAIL_I(SELFTEST_FAIL_I),
  .EARTH_SENSE_WIRE_A_I(EARTH_SENSE_WIRE_A_I), .MAIN_ALARM_RELAY_O(MAIN_ALARM_RELAY_O),
  .WARNING_RELAY_O(WARNING_RELAY_O), .LOCAL_WR_I(LOCAL_WR_I), .SETUP_UNLOCKED_O(SETUP_UNLOCKED_O),
  .LOCAL_WR_ERR_O(LOCAL_WR_ERR_O));
